// >>> ftc_pkg.sv
// Shared constants, register map and state layout of the free-running timer.
`default_nettype none
package ftc_pkg;
    // ------------------------------------------------------------------
    // Register map (byte registers)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL_ONE = 4'h0;
    localparam logic [3:0] OFS_CTRL_TWO = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;
    localparam logic [3:0] OFS_CNT_HI = 4'h3;
    localparam logic [3:0] OFS_CNT_LO = 4'h4;
    localparam logic [3:0] OFS_ALT_HI = 4'h5;
    localparam logic [3:0] OFS_ALT_LO = 4'h6;
    localparam logic [3:0] OFS_CMP1_HI = 4'h7;
    localparam logic [3:0] OFS_CMP1_LO = 4'h8;
    localparam logic [3:0] OFS_CMP2_HI = 4'h9;
    localparam logic [3:0] OFS_CMP2_LO = 4'hA;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CR1_COMPARE_IRQ_ENABLE_BIT = 6;
    localparam int CR1_OVERFLOW_IRQ_ENABLE_BIT = 5;
    localparam int CR1_FOLV2_BIT = 4;
    localparam int CR1_FOLV1_BIT = 3;
    localparam int CR1_OLVL2_BIT = 2;
    localparam int CR1_OLVL1_BIT = 0;
    localparam int CR2_PEN1_BIT = 7;
    localparam int CR2_PEN2_BIT = 6;
    localparam int CR2_PRESC_LSB = 2;
    localparam int SR_OCF1_BIT = 6;
    localparam int SR_TOF_BIT = 5;
    localparam int SR_OCF2_BIT = 3;

    // ------------------------------------------------------------------
    // Reset values and prescaler
    // ------------------------------------------------------------------
    localparam logic [15:0] COUNT_RESET = 16'hFFFC;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] CMP_RESET = 16'h8000;
    localparam logic [2:0] DIV2_MASK = 3'h1;
    localparam logic [2:0] DIV4_MASK = 3'h3;
    localparam logic [2:0] DIV8_MASK = 3'h7;

    typedef enum logic [1:0] {
        PRE_DIV4 = 2'b00,
        PRE_DIV2 = 2'b01,
        PRE_DIV8 = 2'b10,
        PRE_RSVD = 2'b11
    } ftc_presc_t;

    // Register bus request from the CPU side.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ftc_bus_t;

    // Whole state of the timer; index 0 is channel one.
    typedef struct packed {
        logic [15:0] count;
        logic [2:0] div;
        logic new_cnt;
        logic compare_irq_enable;
        logic overflow_irq_enable;
        logic [1:0] folv;
        logic [1:0] olvl;
        logic [1:0] pin_en;
        ftc_presc_t presc;
        logic overflow_flag;
        logic [1:0] ocf;
        logic arm_tof;
        logic [1:0] arm_ocf;
        logic lat_valid;
        logic [7:0] lat;
        logic [1:0][15:0] cmp;
        logic [1:0] inhibit;
        logic [1:0] pin;
        logic irq;
        logic [7:0] rdata;
    } ftc_state_t;

    localparam ftc_state_t ST_RESET = '{
        count: COUNT_RESET,
        cmp: {CMP_RESET, CMP_RESET},
        presc: PRE_DIV4,
        default: '0
    };
endpackage
`default_nettype wire

// >>> ftc_timer.sv
// Sixteen-bit free-running timer with two output-compare channels.
//
// Design decisions made here: the register addresses and strobed register access.
`default_nettype none
// ----------------------------------------------------------------------
// How it works
// - A 16-bit counter counts up once per prescaled timer tick.
// - Main and alternate views show the same count; alternate never clears overflow.
// - Writing either view's low byte reloads the counter with FFFCh.
// - Reset loads FFFCh, the only value ever reloaded.
// - Prescale 00 divides by 4, 01 by 2, 10 by 8, 11 reserved.
// - High-byte read latches low byte until the low byte is read.
// - Low-byte read without pending latch returns the live low byte.
// - Wrap from FFFFh to 0000h sets the overflow flag.
// - Overflow interrupt only with its enable set and CPU mask clear.
// - Status read with flag set, then main low-byte access clears overflow.
// - Counting continues in wait, freezes in halt, resumes from held count.
// - Two 16-bit compare values are checked against the counter each tick.
// - Compare values are software read/write, never hardware changed, reset 8000h.
// - A match sets the channel flag and drives its programmed level.
// - Compare pin latches stay low throughout reset.
// - Compare interrupt only with shared enable set and CPU mask clear.
// - Pin enable routes the compare signal onto the pin.
// - Status read with flag set, then compare low access clears match flag.
// - Writing compare high byte inhibits compare until low byte written.
// - Divide-by-2 matches at equal count; other rates at compare plus one.
// ----------------------------------------------------------------------
module ftc_timer
    import ftc_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire ftc_bus_t bus,
    output logic [7:0] rd_data,
    input wire logic halt_mode,
    input wire logic cpu_irq_mask,
    output logic timer_irq,
    output logic [1:0] compare_output_pin,
    output logic [1:0] compare_pin_enable
);
    ftc_state_t st_reg;
    ftc_state_t st_next;
    logic tick;
    logic [2:0] div_mask;
    logic acc_cnt_lo;
    logic reload;
    logic tof_set;
    logic [1:0] match;
    logic [1:0] acc_cmp_lo;
    logic [1:0] wr_cmp_hi;

    // Byte address of a compare register of one channel.
    function automatic logic [3:0] cmp_addr(input int ch, input logic hi);
        if (ch == 0)
        begin
            return hi ? OFS_CMP1_HI : OFS_CMP1_LO;
        end
        return hi ? OFS_CMP2_HI : OFS_CMP2_LO;
    endfunction

    // ------------------------------------------------------------------
    // Access decode and prescaler tick
    // ------------------------------------------------------------------
    // Reads and writes of the main low byte both take part in clearing overflow.
    assign acc_cnt_lo = (bus.rd || bus.wr) && bus.addr == OFS_CNT_LO;
    assign reload = bus.wr && (bus.addr == OFS_CNT_LO || bus.addr == OFS_ALT_LO);
    assign div_mask = (st_reg.presc == PRE_DIV2) ? DIV2_MASK :
        (st_reg.presc == PRE_DIV8) ? DIV8_MASK : DIV4_MASK;
    // The reserved prescale code stops the timer rather than guess a rate.
    assign tick = !halt_mode && st_reg.presc != PRE_RSVD
        && ((st_reg.div & div_mask) == div_mask);
    assign tof_set = tick && !reload && st_reg.count == COUNT_MAX;

    // Per-channel decode and match detection.
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_chan
            logic [15:0] target;
            assign acc_cmp_lo[i] = (bus.rd || bus.wr) && bus.addr == cmp_addr(i, 1'b0);
            assign wr_cmp_hi[i] = bus.wr && bus.addr == cmp_addr(i, 1'b1);
            // Slower rates see the new count one prescaler step late, hence plus one.
            assign target = (st_reg.presc == PRE_DIV2) ? st_reg.cmp[i] :
                st_reg.cmp[i] + 16'h0001;
            // Only the first cycle of a new count may match, so one count is one event.
            assign match[i] = st_reg.new_cnt && !st_reg.inhibit[i]
                && st_reg.count == target;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        st_next = st_reg;
        st_next.rdata = 8'h00;
        st_next.new_cnt = tick;
        // The divider freezes in halt so the phase is kept across a wake-up.
        if (!halt_mode)
        begin
            st_next.div = st_reg.div + 3'h1;
        end
        if (reload)
        begin
            st_next.count = COUNT_RESET;
        end
        else if (tick)
        begin
            st_next.count = st_reg.count + 16'h0001;
        end

        // Register reads and their side effects.
        if (bus.rd)
        begin
            case (bus.addr)
                OFS_CTRL_ONE:
                begin
                    st_next.rdata[CR1_COMPARE_IRQ_ENABLE_BIT] = st_reg.compare_irq_enable;
                    st_next.rdata[CR1_OVERFLOW_IRQ_ENABLE_BIT] = st_reg.overflow_irq_enable;
                    st_next.rdata[CR1_FOLV2_BIT] = st_reg.folv[1];
                    st_next.rdata[CR1_FOLV1_BIT] = st_reg.folv[0];
                    st_next.rdata[CR1_OLVL2_BIT] = st_reg.olvl[1];
                    st_next.rdata[CR1_OLVL1_BIT] = st_reg.olvl[0];
                end
                OFS_CTRL_TWO:
                begin
                    st_next.rdata[CR2_PEN1_BIT] = st_reg.pin_en[0];
                    st_next.rdata[CR2_PEN2_BIT] = st_reg.pin_en[1];
                    st_next.rdata[CR2_PRESC_LSB +: 2] = st_reg.presc;
                end
                OFS_STATUS:
                begin
                    st_next.rdata[SR_OCF1_BIT] = st_reg.ocf[0];
                    st_next.rdata[SR_TOF_BIT] = st_reg.overflow_flag;
                    st_next.rdata[SR_OCF2_BIT] = st_reg.ocf[1];
                    // First step of a flag clear: only flags seen set are armed.
                    st_next.arm_tof = st_reg.overflow_flag;
                    st_next.arm_ocf = st_reg.ocf;
                end
                OFS_CNT_HI, OFS_ALT_HI:
                begin
                    st_next.rdata = st_reg.count[15:8];
                    // A repeated high read keeps the first latched low byte.
                    if (!st_reg.lat_valid)
                    begin
                        st_next.lat = st_reg.count[7:0];
                        st_next.lat_valid = 1'b1;
                    end
                end
                OFS_CNT_LO, OFS_ALT_LO:
                begin
                    st_next.rdata = st_reg.lat_valid ? st_reg.lat : st_reg.count[7:0];
                    st_next.lat_valid = 1'b0;
                end
                OFS_CMP1_HI:
                begin
                    st_next.rdata = st_reg.cmp[0][15:8];
                end
                OFS_CMP1_LO:
                begin
                    st_next.rdata = st_reg.cmp[0][7:0];
                end
                OFS_CMP2_HI:
                begin
                    st_next.rdata = st_reg.cmp[1][15:8];
                end
                OFS_CMP2_LO:
                begin
                    st_next.rdata = st_reg.cmp[1][7:0];
                end
                default:
                begin
                    st_next.rdata = 8'h00;
                end
            endcase
        end

        // Register writes; count views and status are read-only apart from reload.
        if (bus.wr)
        begin
            case (bus.addr)
                OFS_CTRL_ONE:
                begin
                    st_next.compare_irq_enable = bus.wdata[CR1_COMPARE_IRQ_ENABLE_BIT];
                    st_next.overflow_irq_enable = bus.wdata[CR1_OVERFLOW_IRQ_ENABLE_BIT];
                    st_next.folv = {bus.wdata[CR1_FOLV2_BIT], bus.wdata[CR1_FOLV1_BIT]};
                    st_next.olvl = {bus.wdata[CR1_OLVL2_BIT], bus.wdata[CR1_OLVL1_BIT]};
                end
                OFS_CTRL_TWO:
                begin
                    st_next.pin_en = {bus.wdata[CR2_PEN2_BIT], bus.wdata[CR2_PEN1_BIT]};
                    st_next.presc = ftc_presc_t'(bus.wdata[CR2_PRESC_LSB +: 2]);
                end
                default:
                begin
                end
            endcase
        end

        // Overflow flag: the main low byte finishes the clear, a new wrap wins.
        if (acc_cnt_lo && st_reg.arm_tof)
        begin
            st_next.overflow_flag = 1'b0;
            st_next.arm_tof = 1'b0;
        end
        if (tof_set)
        begin
            st_next.overflow_flag = 1'b1;
        end

        // Compare channels.
        for (int i = 0; i < 2; i++)
        begin
            if (wr_cmp_hi[i])
            begin
                st_next.cmp[i][15:8] = bus.wdata;
                st_next.inhibit[i] = 1'b1;
            end
            if (bus.wr && bus.addr == cmp_addr(i, 1'b0))
            begin
                st_next.cmp[i][7:0] = bus.wdata;
                st_next.inhibit[i] = 1'b0;
            end
            if (acc_cmp_lo[i] && st_reg.arm_ocf[i])
            begin
                st_next.ocf[i] = 1'b0;
                st_next.arm_ocf[i] = 1'b0;
            end
            if (match[i])
            begin
                st_next.ocf[i] = 1'b1;
            end
            // Without pin enable the pin belongs to general I/O and its latch holds.
            if (st_reg.pin_en[i] && (match[i] || st_reg.folv[i]))
            begin
                st_next.pin[i] = st_reg.olvl[i];
            end
        end

        // One shared request line; the CPU mask holds it pending.
        st_next.irq = !cpu_irq_mask && ((st_next.overflow_flag && st_reg.overflow_irq_enable)
            || (|st_next.ocf && st_reg.compare_irq_enable));
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset wins over everything, so pin latches stay low while it is held.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            st_reg <= ST_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state register.
    assign rd_data = st_reg.rdata;
    assign timer_irq = st_reg.irq;
    assign compare_output_pin = st_reg.pin;
    assign compare_pin_enable = st_reg.pin_en;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_status_armed;
        bus.rd && bus.addr == OFS_STATUS && st_reg.overflow_flag && !tof_set;
    endsequence

    sequence s_main_lo_access;
        (!bus.rd || bus.addr != OFS_STATUS) && acc_cnt_lo && !tof_set;
    endsequence

    sequence s_hi_read_fresh;
        bus.rd && (bus.addr == OFS_CNT_HI || bus.addr == OFS_ALT_HI) && !st_reg.lat_valid;
    endsequence

    sequence s_lo_read;
        bus.rd && (bus.addr == OFS_CNT_LO || bus.addr == OFS_ALT_LO);
    endsequence

    // Software issues the two steps of a flag clear with one idle bus cycle between.
    sequence s_bus_idle;
        !bus.rd && !bus.wr;
    endsequence

    sequence s_cmp_armed;
        bus.rd && bus.addr == OFS_STATUS && st_reg.ocf[0];
    endsequence

    a_reset_values: assert property (disable iff (1'b0)
        $fell(sys_rst) |-> st_reg.count == COUNT_RESET && st_reg.cmp[0] == CMP_RESET
        && st_reg.cmp[1] == CMP_RESET && compare_output_pin == 2'b00)
        else $error("Timer state not at reset values after reset.");

    a_low_reload: assert property (reload |=> st_reg.count == COUNT_RESET)
        else $error("Low byte write did not reload the counter.");

    a_count_advance: assert property (tick && !reload |=>
        st_reg.count == $past(st_reg.count) + 16'h0001)
        else $error("Counter did not advance on a tick.");

    a_overflow_set: assert property (tof_set |=> st_reg.overflow_flag && st_reg.count == 16'h0000)
        else $error("Wrap did not set the overflow flag.");

    a_overflow_clear: assert property (s_status_armed ##1 s_bus_idle
        ##1 s_main_lo_access |=> !st_reg.overflow_flag)
        else $error("Overflow flag not cleared by status then low byte access.");

    a_alt_keeps_flag: assert property (st_reg.overflow_flag && !acc_cnt_lo |=> st_reg.overflow_flag)
        else $error("Overflow flag cleared without main low byte access.");

    a_irq_gating: assert property (timer_irq |-> !$past(cpu_irq_mask)
        && ($past(st_reg.overflow_irq_enable) || $past(st_reg.compare_irq_enable)))
        else $error("Interrupt raised while masked or disabled.");

    a_halt_freeze: assert property (halt_mode && !reload |=> $stable(st_reg.count))
        else $error("Counter moved during halt.");

    a_latch_hold: assert property (s_hi_read_fresh
        ##1 !(bus.rd && (bus.addr == OFS_CNT_LO || bus.addr == OFS_ALT_LO))
        ##1 s_lo_read |=> rd_data == $past(st_reg.count[7:0], 3))
        else $error("Low byte read did not return the latched value.");

    a_div2_rate: assert property (tick && st_reg.presc == PRE_DIV2 |=> !tick)
        else $error("Divide-by-2 ticked on consecutive cycles.");

    a_div8_rate: assert property (tick && st_reg.presc == PRE_DIV8 |=>
        (!tick || st_reg.presc != PRE_DIV8)[*7])
        else $error("Divide-by-8 ticked too early.");

    a_match_output: assert property (match[0] |=> st_reg.ocf[0]
        && (!$past(st_reg.pin_en[0]) || compare_output_pin[0] == $past(st_reg.olvl[0])))
        else $error("Channel one match did not set flag or pin.");

    a_cmp_inhibit: assert property (wr_cmp_hi[1] |=> st_reg.inhibit[1] && !match[1])
        else $error("Compare not inhibited after high byte write.");

    a_match_target: assert property (match[0] && st_reg.presc != PRE_DIV2 |->
        st_reg.count == st_reg.cmp[0] + 16'h0001 && $past(tick))
        else $error("Slow-rate match not at compare value plus one.");

    // Read paths, flag clears and pin ownership seen from the outside.
    a_alt_view_same: assert property (bus.rd && (bus.addr == OFS_CNT_HI
        || bus.addr == OFS_ALT_HI) |=> rd_data == $past(st_reg.count[15:8]))
        else $error("Count view high byte differs from the count.");

    a_live_low_read: assert property (s_lo_read ##0 !st_reg.lat_valid
        |=> rd_data == $past(st_reg.count[7:0]))
        else $error("Low byte read without latch did not return the live count.");

    a_match_clear: assert property (s_cmp_armed ##1 s_bus_idle
        ##1 (acc_cmp_lo[0] && !match[0]) |=> !st_reg.ocf[0])
        else $error("Match flag not cleared by status then compare low access.");

    a_irq_pending: assert property (st_reg.overflow_flag && st_reg.overflow_irq_enable && !cpu_irq_mask
        && !(acc_cnt_lo && st_reg.arm_tof) |=> timer_irq)
        else $error("Pending overflow request not raised once unmasked.");

    a_cmp_sw_only: assert property (!bus.wr |=> $stable(st_reg.cmp))
        else $error("Compare value changed without a software write.");

    a_pin_gpio_hold: assert property (!st_reg.pin_en[1]
        |=> $stable(compare_output_pin[1]))
        else $error("Channel two pin moved while it belongs to general I/O.");
endmodule
`default_nettype wire

// >>> ftc_timer_test.sv
// Self-checking bench for the free-running timer with two output-compare channels.
`default_nettype none
module ftc_timer_test
    import ftc_pkg::*;
(
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Stimulus signals and counters
    // ------------------------------------------------------------------
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    ftc_bus_t bus = '0;
    logic halt_mode = 1'b1;
    logic cpu_irq_mask = 1'b1;
    logic [7:0] rd_data;
    logic timer_irq;
    logic [1:0] compare_output_pin;
    logic [1:0] compare_pin_enable;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;

    // Reset-value table: controls, status, compares, an unmapped slot, then a 16-bit count read.
    localparam logic [3:0] RST_ADDR [10] = '{OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_STATUS,
        OFS_CMP1_HI, OFS_CMP1_LO, OFS_CMP2_HI, OFS_CMP2_LO, 4'hF, OFS_CNT_HI, OFS_ALT_LO};
    localparam logic [7:0] RST_EXP [10] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00,
        8'h00, 8'hFF, 8'hFC};

    ftc_timer i_dut (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .bus(bus),
        .rd_data(rd_data),
        .halt_mode(halt_mode),
        .cpu_irq_mask(cpu_irq_mask),
        .timer_irq(timer_irq),
        .compare_output_pin(compare_output_pin),
        .compare_pin_enable(compare_pin_enable)
    );

    // 10 MHz clock.
    always #50 core_clk = ~core_clk;

    // Cycle ceiling; the whole sequence needs well under a thousand cycles.
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------------
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check2(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe; the bus returns to idle at the next edge.
    task automatic reg_write(input logic [3:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge core_clk);
        bus <= '0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic read_expect(input logic [3:0] addr, input logic [7:0] exp);
        @(posedge core_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge core_clk);
        bus <= '0;
        #1;
        check8(rd_data, exp);
    endtask

    // Lets the timer run for n cycles; halt freezes divider and counter, so n/divisor ticks land.
    task automatic run_cycles(input int n);
        @(posedge core_clk);
        halt_mode <= 1'b0;
        repeat (n) @(posedge core_clk);
        halt_mode <= 1'b1;
    endtask

    // Changes the CPU mask and waits for the registered request to follow.
    task automatic set_mask(input logic v);
        @(posedge core_clk);
        cpu_irq_mask <= v;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (19) @(posedge core_clk);
        #1;
        check2(compare_output_pin, 2'b00);
        @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 10; i++)
        begin
            read_expect(RST_ADDR[i], RST_EXP[i]);
        end
        check2(compare_pin_enable, 2'b00);

        // Buffered 16-bit read across a wrap; the latch must survive a second high read.
        reg_write(OFS_ALT_LO, 8'h55);
        read_expect(OFS_CNT_HI, 8'hFF);
        run_cycles(40);
        read_expect(OFS_CNT_HI, 8'h00);
        read_expect(OFS_ALT_LO, 8'hFC);
        read_expect(OFS_CNT_LO, 8'h06);

        // Overflow request is held back by the mask and released when it clears.
        reg_write(OFS_CTRL_ONE, 8'h20);
        set_mask(1'b1);
        check2({1'b0, timer_irq}, 2'b00);
        set_mask(1'b0);
        check2({1'b0, timer_irq}, 2'b01);
        read_expect(OFS_STATUS, 8'h20);
        read_expect(OFS_ALT_LO, 8'h06);
        read_expect(OFS_STATUS, 8'h20);
        read_expect(OFS_CNT_LO, 8'h06);
        read_expect(OFS_STATUS, 8'h00);
        check2({1'b0, timer_irq}, 2'b00);

        // Divide by 4: flag one count late; channel two inhibited after a lone high write.
        reg_write(OFS_CTRL_TWO, 8'hC0);
        reg_write(OFS_CTRL_ONE, 8'h41);
        reg_write(OFS_CMP1_HI, 8'h00);
        reg_write(OFS_CMP1_LO, 8'h03);
        reg_write(OFS_CMP2_HI, 8'h00);
        reg_write(OFS_CNT_LO, 8'h00);
        run_cycles(28);
        read_expect(OFS_STATUS, 8'h20);
        check2(compare_output_pin, 2'b00);
        run_cycles(4);
        // Compare readback comes before the status read, which would arm the flag clear.
        read_expect(OFS_CMP1_HI, 8'h00);
        read_expect(OFS_CMP1_LO, 8'h03);
        read_expect(OFS_STATUS, 8'h60);
        check2(compare_output_pin, 2'b01);
        check2(compare_pin_enable, 2'b11);
        check2({1'b0, timer_irq}, 2'b01);
        set_mask(1'b1);
        check2({1'b0, timer_irq}, 2'b00);
        read_expect(OFS_STATUS, 8'h60);
        reg_write(OFS_CMP1_LO, 8'h03);
        read_expect(OFS_STATUS, 8'h20);

        // Divide by 2: both channels match on the very count equal to their compare value.
        reg_write(OFS_CMP2_LO, 8'h03);
        reg_write(OFS_CTRL_TWO, 8'hC4);
        reg_write(OFS_CTRL_ONE, 8'h45);
        reg_write(OFS_CNT_LO, 8'h00);
        run_cycles(12);
        read_expect(OFS_STATUS, 8'h20);
        run_cycles(2);
        read_expect(OFS_STATUS, 8'h68);
        check2(compare_output_pin, 2'b11);

        // Divide by 8 from divider phase 6: two ticks in 17 cycles; code 11 stops the count.
        reg_write(OFS_CTRL_TWO, 8'hC8);
        reg_write(OFS_ALT_LO, 8'h00);
        run_cycles(17);
        read_expect(OFS_ALT_LO, 8'hFE);
        reg_write(OFS_CTRL_TWO, 8'hCC);
        read_expect(OFS_CTRL_TWO, 8'hCC);
        run_cycles(8);
        read_expect(OFS_ALT_LO, 8'hFE);
        // Forced level on channel one drives its low level; channel two keeps its latch.
        reg_write(OFS_CTRL_ONE, 8'h4C);
        read_expect(OFS_CTRL_ONE, 8'h4C);
        check2(compare_output_pin, 2'b10);

        // A second reset in mid-run drops the pin latches and restarts from the reset count.
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check2(compare_output_pin, 2'b00);
        @(posedge core_clk);
        sys_rst <= 1'b0;
        read_expect(OFS_CNT_HI, 8'hFF);
        read_expect(OFS_CNT_LO, 8'hFC);
        tally_and_finish();
    end
endmodule
`default_nettype wire
